//--- bst_defines.vh
// shared constants of the transmit scheduler
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH

// ****************************************************************
// timebase
// ****************************************************************
`define BST_CLK_HZ 10000000
`define BST_MS_PER_S 1000
`define BST_WAKE_MS 3
`define BST_BURST_MS 15
`define BST_BEACON_S 2

// ****************************************************************
// register byte offsets
// ****************************************************************
`define BST_REG_CTRL 4'h0
`define BST_REG_IDENT 4'h4
`define BST_REG_STATUS 4'h8
`define BST_REG_TXCOUNT 4'hc

// ****************************************************************
// register fields and reset values
// ****************************************************************
`define BST_CTRL_EN_BIT 0
`define BST_CTRL_RESET 32'h0000_0001
`define BST_IDENT_RESET 32'h1234_5678
`define BST_ST_READY_BIT 0
`define BST_ST_BEACON_BIT 1
`define BST_ST_ACTIVE_BIT 2
`define BST_ST_KIND_BIT 3
`define BST_ST_SW_LSB 4
`define BST_ST_STRAP_LSB 8

// ****************************************************************
// bus answers and packet kinds
// ****************************************************************
`define BST_RESP_OKAY 2'b00
`define BST_RESP_SLVERR 2'b10
`define BST_KIND_SWITCH 1'b0
`define BST_KIND_BEACON 1'b1

`endif

//--- bst_rx_model.sv
// remote receiver model
`timescale 1ns/100ps
module bst_rx_model (
    input wire clk,                 // system clock
    input wire rst,                 // synchronous reset, high
    input wire start,               // packet start pulse
    input wire kind,                // 1 beacon, 0 switch
    input wire [2:0] sw,            // switch levels carried
    input wire [31:0] ident,        // identity carried
    output logic [15:0] beacon_cnt, // beacons decoded
    output logic [15:0] switch_cnt, // switch packets decoded
    output logic [31:0] last_ident  // identity of last beacon
);
    // ****************************************************************
    // decoder
    // ****************************************************************
    // sort packets by kind mark
    always @(posedge clk) begin
        if (rst) begin
            beacon_cnt <= 16'h0000;
            switch_cnt <= 16'h0000;
            last_ident <= 32'h0000_0000;
        end else if (start && kind) begin
            beacon_cnt <= beacon_cnt + 16'h0001;
            last_ident <= ident;
        end else if (start) begin
            switch_cnt <= switch_cnt + 16'h0001;
        end
    end
endmodule // bst_rx_model

//--- bst_scheduler.v
// transmit scheduler with register slave
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "bst_defines.vh"
module bst_scheduler #(
    parameter CYCLES_PER_MS = `BST_CLK_HZ / `BST_MS_PER_S, // shortens sims
    parameter BURST_MS = `BST_BURST_MS,                     // burst length
    parameter BEACON_MS = `BST_BEACON_S * `BST_MS_PER_S,   // beacon period
    parameter WAKE_MS = `BST_WAKE_MS                        // start-up wait
) (
    input wire CLK,                  // 10 MHz clock
    input wire SYS_RST,              // synchronous reset, high
    input wire SWITCH_INPUT_A,       // switch a pin
    input wire SWITCH_INPUT_B,       // switch b pin
    input wire SWITCH_INPUT_C,       // switch c pin
    input wire [2:0] MODE_STRAP,     // mode strap pins
    output reg TRANSMIT_INDICATOR,   // high during a burst
    output reg TX_START,             // pulse: packet starts
    output reg TX_KIND,              // 1 beacon, 0 switch
    output reg [2:0] TX_SWITCHES,    // switch levels in packet
    output reg [31:0] TX_IDENT,      // identity code in packet
    input wire [3:0] AWADDR,         // write address
    input wire AWVALID,              // write address valid
    output reg AWREADY,              // write address ready
    input wire [31:0] WDATA,         // write data
    input wire [3:0] WSTRB,          // write byte strobes
    input wire WVALID,               // write data valid
    output reg WREADY,               // write data ready
    output reg [1:0] BRESP,          // write response
    output reg BVALID,               // write response valid
    input wire BREADY,               // write response ready
    input wire [3:0] ARADDR,         // read address
    input wire ARVALID,              // read address valid
    output reg ARREADY,              // read address ready
    output reg [31:0] RDATA,         // read data
    output reg [1:0] RRESP,          // read response
    output reg RVALID,               // read data valid
    input wire RREADY                // read data ready
);
    // ****************************************************************
    // states and widths
    // ****************************************************************
    localparam [1:0] ST_WAKE = 2'd0;   // start-up wait
    localparam [1:0] ST_IDLE = 2'd1;   // low-power between bursts
    localparam [1:0] ST_BURST = 2'd2;  // transmitting
    localparam [1:0] ST_OFF = 2'd3;    // straps chose another mode
    localparam CW = 16;                // ms counter width
    localparam [CW-1:0] BURST_LAST = BURST_MS - 1;
    localparam [CW-1:0] BEACON_LAST = BEACON_MS - 1;
    localparam [CW-1:0] WAKE_LAST = WAKE_MS - 1;

    // merge a write under byte strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************************************
    // signals
    // ****************************************************************
    wire [5:0] pins_sync;             // synchronised switches and straps
    wire [2:0] sw;                    // switches, active high
    wire [2:0] strap;                 // straps after synchroniser
    wire ms_tick;                     // one pulse per ms
    reg [2:0] sw_prev_ff;             // switches last cycle
    reg [2:0] strap_ff;               // straps caught once
    reg [1:0] state_ff;               // scheduler state
    reg [1:0] nxt_state;
    reg [CW-1:0] ms_cnt_ff;           // ms in wake or burst
    reg [CW-1:0] nxt_ms_cnt;
    reg [CW-1:0] beacon_cnt_ff;       // ms since last beacon
    reg [CW-1:0] nxt_beacon_cnt;
    reg beacon_due_ff;                // beacon interval elapsed
    reg nxt_beacon_due;
    reg start;                        // a burst begins this cycle
    reg start_kind;                   // its kind
    reg [31:0] ctrl_ff;               // control register
    reg [31:0] ident_ff;              // serial identity code
    reg [31:0] txcount_ff;            // bursts sent
    reg [3:0] aw_addr_ff;             // held write address
    reg aw_held_ff;                   // write address taken
    reg [31:0] w_data_ff;             // held write data
    reg [3:0] w_strb_ff;              // held strobes
    reg w_held_ff;                    // write data taken
    wire sw_any = |sw;                // any switch asserted
    wire sw_rise = |(sw & ~sw_prev_ff); // a switch just went high
    wire enabled = ctrl_ff[`BST_CTRL_EN_BIT];
    wire [31:0] status;               // live status word

    // ****************************************************************
    // pins and timebase
    // ****************************************************************
    bst_sync2 #(.WIDTH(6)) u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .d_async({MODE_STRAP, SWITCH_INPUT_C, SWITCH_INPUT_B, SWITCH_INPUT_A}),
        .q_sync(pins_sync)
    );
    assign sw = pins_sync[2:0];       // high level means asserted
    assign strap = pins_sync[5:3];

    // restart on each burst so a burst lasts whole ms periods
    bst_tick #(.CYCLES(CYCLES_PER_MS), .CW(CW)) u_tick (
        .clk(CLK),
        .rst(SYS_RST),
        .restart(start),
        .tick(ms_tick)
    );

    // ****************************************************************
    // scheduler next state
    // ****************************************************************
    always @* begin
        nxt_state = state_ff;
        nxt_ms_cnt = ms_cnt_ff;
        nxt_beacon_cnt = beacon_cnt_ff;
        nxt_beacon_due = beacon_due_ff;
        start = 1'b0;
        start_kind = `BST_KIND_SWITCH;
        // beacon interval runs in idle and burst alike
        if ((state_ff == ST_IDLE || state_ff == ST_BURST) && ms_tick) begin
            if (beacon_cnt_ff == BEACON_LAST) begin
                nxt_beacon_due = 1'b1;
            end else begin
                nxt_beacon_cnt = beacon_cnt_ff + 1'b1;
            end
        end
        case (state_ff)
            ST_WAKE: begin
                if (ms_tick) begin
                    nxt_ms_cnt = ms_cnt_ff + 1'b1;
                    if (ms_cnt_ff == WAKE_LAST) begin
                        // straps decide once
                        nxt_state = (strap == 3'b000) ? ST_IDLE : ST_OFF;
                        nxt_ms_cnt = {CW{1'b0}};
                    end
                end
            end
            ST_IDLE: begin
                if (enabled && sw_any) begin
                    start = 1'b1;             // no wait for the interval
                end else if (enabled && beacon_due_ff) begin
                    start = 1'b1;             // periodic identity packet
                    start_kind = `BST_KIND_BEACON;
                end
            end
            ST_BURST: begin
                if (enabled && sw_rise) begin
                    start = 1'b1;             // fresh press cuts
                end else if (ms_tick && ms_cnt_ff == BURST_LAST) begin
                    if (enabled && sw_any) begin
                        start = 1'b1;         // repeat while held
                    end else if (enabled && beacon_due_ff) begin
                        start = 1'b1;
                        start_kind = `BST_KIND_BEACON;
                    end else begin
                        nxt_state = ST_IDLE;  // back to low power
                    end
                end else if (ms_tick) begin
                    nxt_ms_cnt = ms_cnt_ff + 1'b1;
                end
            end
            ST_OFF: begin
                nxt_state = ST_OFF;           // other modes live elsewhere
            end
            default: begin
                nxt_state = ST_WAKE;
            end
        endcase
        if (start) begin
            nxt_state = ST_BURST;
            nxt_ms_cnt = {CW{1'b0}};
            if (start_kind == `BST_KIND_BEACON) begin
                nxt_beacon_cnt = {CW{1'b0}};
                nxt_beacon_due = 1'b0;
            end
        end
    end

    // ****************************************************************
    // scheduler registers and packet outputs
    // ****************************************************************
    always @(posedge CLK) begin
        if (SYS_RST) begin
            state_ff <= ST_WAKE;
            ms_cnt_ff <= {CW{1'b0}};
            beacon_cnt_ff <= {CW{1'b0}};
            beacon_due_ff <= 1'b1;           // first beacon right after wake
            sw_prev_ff <= 3'b000;
            strap_ff <= 3'b000;
            txcount_ff <= 32'h0000_0000;
            TRANSMIT_INDICATOR <= 1'b0;
            TX_START <= 1'b0;
            TX_KIND <= `BST_KIND_SWITCH;
            TX_SWITCHES <= 3'b000;
            TX_IDENT <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            ms_cnt_ff <= nxt_ms_cnt;
            beacon_cnt_ff <= nxt_beacon_cnt;
            beacon_due_ff <= nxt_beacon_due;
            sw_prev_ff <= sw;
            // copy at end of wake only
            if (state_ff == ST_WAKE && ms_tick && ms_cnt_ff == WAKE_LAST) begin
                strap_ff <= strap;
            end
            TX_START <= start;
            TRANSMIT_INDICATOR <= (nxt_state == ST_BURST);
            if (start) begin
                txcount_ff <= txcount_ff + 1'b1;
                TX_KIND <= start_kind;       // tells the receiver why
                TX_IDENT <= ident_ff;
                // beacon reports as an input-one event
                TX_SWITCHES <= (start_kind == `BST_KIND_BEACON) ?
                               (sw | 3'b001) : sw;
            end
        end
    end

    // ****************************************************************
    // register write channel
    // ****************************************************************
    // address and data in either order
    always @(posedge CLK) begin
        if (SYS_RST) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= `BST_RESP_OKAY;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            ctrl_ff <= `BST_CTRL_RESET;
            ident_ff <= `BST_IDENT_RESET;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_addr_ff <= AWADDR;
                aw_held_ff <= 1'b1;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
                w_held_ff <= 1'b1;
                WREADY <= 1'b0;
            end
            if (aw_held_ff && w_held_ff && !BVALID) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= `BST_RESP_OKAY;
                case (aw_addr_ff)
                    `BST_REG_CTRL: ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff);
                    `BST_REG_IDENT: ident_ff <= merge(ident_ff, w_data_ff, w_strb_ff);
                    `BST_REG_STATUS: BRESP <= `BST_RESP_OKAY;  // read-only
                    `BST_REG_TXCOUNT: BRESP <= `BST_RESP_OKAY; // read-only
                    default: BRESP <= `BST_RESP_SLVERR;        // unmapped
                endcase
            end
            // reopen after the response
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // register read channel
    // ****************************************************************
    assign status = {21'h00_0000, strap_ff, 1'b0, sw,
                     TX_KIND, TRANSMIT_INDICATOR,
                     (state_ff == ST_IDLE || state_ff == ST_BURST),
                     (state_ff != ST_WAKE)};

    // one read at a time
    always @(posedge CLK) begin
        if (SYS_RST) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= `BST_RESP_OKAY;
        end else begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RRESP <= `BST_RESP_OKAY;
                case (ARADDR)
                    `BST_REG_CTRL: RDATA <= ctrl_ff;
                    `BST_REG_IDENT: RDATA <= ident_ff;
                    `BST_REG_STATUS: RDATA <= status;
                    `BST_REG_TXCOUNT: RDATA <= txcount_ff;
                    default: begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= `BST_RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end
endmodule // bst_scheduler

//--- bst_scheduler_chk.sv
// port checker for the transmit scheduler
`timescale 1ns/100ps
module bst_scheduler_chk #(
    parameter CYCLES_PER_MS = 10000, // ms divider
    parameter BURST_MS = 15,         // burst length
    parameter BEACON_MS = 2000,      // beacon period
    parameter WAKE_MS = 3            // start-up wait
) (
    input wire CLK,                // clock
    input wire SYS_RST,            // reset, high
    input wire SWITCH_INPUT_A,     // switch a
    input wire SWITCH_INPUT_B,     // switch b
    input wire SWITCH_INPUT_C,     // switch c
    input wire TRANSMIT_INDICATOR, // burst indicator
    input wire TX_START,           // start pulse
    input wire TX_KIND,            // packet kind
    input wire [2:0] TX_SWITCHES   // packet switch levels
);
    localparam int BLEN = BURST_MS * CYCLES_PER_MS; // burst cycles
    localparam int PER = BEACON_MS * CYCLES_PER_MS; // beacon cycles
    localparam int WAKE = WAKE_MS * CYCLES_PER_MS;  // wake cycles
    logic [31:0] since_start_ff; // cycles since a start
    logic [31:0] since_beacon_ff; // cycles since a beacon
    logic [31:0] since_rst_ff; // cycles since reset release
    logic armed_ff; // beacon mode live
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // saturate so a long idle never wraps into a false gap
    function automatic [31:0] sat_inc(input [31:0] v);
        sat_inc = (&v) ? v : v + 32'h0000_0001;
    endfunction
    // ****************************************************************
    // helper counters
    // ****************************************************************
    always @(posedge CLK) begin
        if (SYS_RST) begin
            since_start_ff <= 32'hffff_ffff;
            since_beacon_ff <= 32'hffff_ffff;
            since_rst_ff <= 32'h0000_0000;
            armed_ff <= 1'b0;
        end else begin
            since_start_ff <= TX_START ? 32'h0000_0001 : sat_inc(since_start_ff);
            since_beacon_ff <= (TX_START && TX_KIND) ? 32'h0000_0001 : sat_inc(since_beacon_ff);
            since_rst_ff <= sat_inc(since_rst_ff);
            armed_ff <= armed_ff | TX_START;
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    start_lights_a: assert property (TX_START |-> TRANSMIT_INDICATOR)
        else $error("indicator low at start");
    start_pulse_a: assert property (TX_START |=> !TX_START)
        else $error("start pulse too long");
    beacon_mark_a: assert property (TX_START && TX_KIND |-> TX_SWITCHES[0])
        else $error("beacon without input one");
    switch_levels_a: assert property (TX_START && !TX_KIND |-> TX_SWITCHES != 3'b000)
        else $error("switch packet all low");
    burst_hold_a: assert property (since_start_ff < BLEN |-> TRANSMIT_INDICATOR)
        else $error("indicator dropped in burst");
    burst_end_a: assert property ($fell(TRANSMIT_INDICATOR) |->
        since_start_ff >= BLEN && since_start_ff <= BLEN + 4)
        else $error("indicator fell off time");
    wake_quiet_a: assert property (since_rst_ff < WAKE |-> !TX_START)
        else $error("packet before wake time");
    rise_send_a: assert property (armed_ff && ($rose(SWITCH_INPUT_A) || $rose(SWITCH_INPUT_B)
        || $rose(SWITCH_INPUT_C)) |-> ##[1:6] TX_START)
        else $error("switch rise not sent");
    beacon_gap_a: assert property (TX_START && TX_KIND |-> since_beacon_ff >= PER - 2)
        else $error("beacons too close");
    cover property (TX_START && TX_KIND);
    cover property (TX_START && !TX_KIND);
    cover property ($fell(TRANSMIT_INDICATOR));
endmodule // bst_scheduler_chk
bind bst_scheduler bst_scheduler_chk #(.CYCLES_PER_MS(CYCLES_PER_MS), .BURST_MS(BURST_MS),
    .BEACON_MS(BEACON_MS), .WAKE_MS(WAKE_MS)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
    .SWITCH_INPUT_A(SWITCH_INPUT_A), .SWITCH_INPUT_B(SWITCH_INPUT_B),
    .SWITCH_INPUT_C(SWITCH_INPUT_C), .TRANSMIT_INDICATOR(TRANSMIT_INDICATOR),
    .TX_START(TX_START), .TX_KIND(TX_KIND), .TX_SWITCHES(TX_SWITCHES));

//--- bst_scheduler_test.sv
// self-checking bench for the transmit scheduler
`timescale 1ns/100ps
module bst_scheduler_test;
    localparam int CPM = 10; // short ms
    localparam int BURST = 3; // burst ms
    localparam int BEACON = 20; // beacon ms
    localparam int WAKE = 3; // wake ms
    logic clk, sys_rst, sw_a, sw_b, sw_c;
    logic [2:0] strap;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata;
    logic awvalid, wvalid, bready, arvalid, rready;
    wire awready, wready, bvalid, arready, rvalid, tx_ind, tx_start, tx_kind;
    wire [1:0] bresp, rresp;
    wire [2:0] tx_sw;
    wire [31:0] rdata, tx_ident, rx_ident;
    wire [15:0] n_beacon, n_switch;
    int fail_count = 0;
    int checked = 0;
    time t_beacon; // last beacon start
    bst_scheduler #(.CYCLES_PER_MS(CPM), .BURST_MS(BURST), .BEACON_MS(BEACON),
        .WAKE_MS(WAKE)) dut (.CLK(clk), .SYS_RST(sys_rst), .SWITCH_INPUT_A(sw_a),
        .SWITCH_INPUT_B(sw_b), .SWITCH_INPUT_C(sw_c), .MODE_STRAP(strap),
        .TRANSMIT_INDICATOR(tx_ind), .TX_START(tx_start), .TX_KIND(tx_kind),
        .TX_SWITCHES(tx_sw), .TX_IDENT(tx_ident), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready));
    bst_rx_model u_rx (.clk(clk), .rst(sys_rst), .start(tx_start), .kind(tx_kind),
        .sw(tx_sw), .ident(tx_ident), .beacon_cnt(n_beacon), .switch_cnt(n_switch),
        .last_ident(rx_ident));
    // ****************************************************************
    // common tasks
    // ****************************************************************
    task automatic give_verdict;
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // a spent wait fails the run
    task automatic hang;
        fail_count++;
        give_verdict;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // offer address and data together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                check(bresp, 2'b00);
                return;
            end
        end
        hang;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                d = rdata;
                check(rresp, 2'b00);
                return;
            end
        end
        hang;
    endtask
    task automatic wait_start(input int bound);
        for (int n = 0; n < bound; n++) begin
            @(posedge clk);
            if (tx_start === 1'b1) return;
        end
        hang;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic sc_first_beacon;
        logic [31:0] d;
        axi_rd(4'h0, d);
        check(d, 32'h0000_0001); // enable on
        axi_rd(4'h4, d);
        check(d, 32'h1234_5678);
        wait_start(WAKE * CPM + 40);
        t_beacon = $time;
        check(tx_kind, 1'b1);
        check(tx_sw, 3'b001);
        check(tx_ident, 32'h1234_5678);
        axi_rd(4'h8, d);
        check(d[1:0], 2'b11);
    endtask
    // new identity, moved straps
    task automatic sc_period;
        int gap;
        axi_wr(4'h4, 32'ha5a5_0f0f);
        strap <= 3'b111;
        wait_start(BEACON * CPM + 40);
        gap = int'(($time - t_beacon) / 100);
        check(gap >= BEACON * CPM - 2 && gap <= BEACON * CPM + 4, 1'b1);
        check(tx_kind, 1'b1);
        check(tx_ind, 1'b1);
        idle(2);
        check(rx_ident, 32'ha5a5_0f0f);
        check(n_beacon, 16'h0002);
        idle(BURST * CPM + 6);
        check(tx_ind, 1'b0);
    endtask
    task automatic sc_switches;
        logic [15:0] n;
        for (int i = 0; i < 3; i++) begin
            {sw_c, sw_b, sw_a} <= 3'b001 << i; // held through a repeat, unused low
            wait_start(8);
            check(tx_kind, 1'b0);
            check(tx_sw, 3'b001 << i);
            wait_start(BURST * CPM + 6);
            check(tx_sw, 3'b001 << i);
            n = n_switch;
            {sw_c, sw_b, sw_a} <= 3'b000;
            idle(BURST * CPM + 8);
            check(n_switch, n + 16'h0001);
        end
        sw_a <= 1'b1;
        wait_start(8);
        idle(5);
        sw_b <= 1'b1; // second rise in burst
        wait_start(8);
        check(tx_sw, 3'b011);
        {sw_c, sw_b, sw_a} <= 3'b000;
        idle(BURST * CPM + 8);
    endtask
    // non-zero straps keep it silent
    task automatic sc_straps;
        logic [31:0] d;
        for (int s = 1; s < 8; s++) begin
            strap <= s[2:0];
            sys_rst <= 1'b1;
            idle(2);
            sys_rst <= 1'b0;
            idle(WAKE * CPM + 10);
            strap <= 3'b000;
            sw_a <= 1'b1;
            idle(BEACON * CPM + 20);
            check(n_beacon + n_switch, 16'h0000);
            axi_rd(4'h8, d);
            check(d[1], 1'b0);
            sw_a <= 1'b0;
        end
    endtask
    // ****************************************************************
    // clock and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        {sw_c, sw_b, sw_a} = 3'b000;
        strap = 3'b000;
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        idle(20);
        sys_rst <= 1'b0;
        sc_first_beacon;
        sc_period;
        sc_switches;
        sc_straps;
        give_verdict;
    end
endmodule // bst_scheduler_test

//--- bst_sync2.v
// two flip-flop synchroniser
`timescale 1ns/100ps
module bst_sync2 #(
    parameter WIDTH = 6
) (
    input wire clk,                 // system clock
    input wire rst,                 // synchronous reset, high
    input wire [WIDTH-1:0] d_async, // pin levels
    output reg [WIDTH-1:0] q_sync   // levels safe to use
);
    // first stage, read only by the second stage
    reg [WIDTH-1:0] meta_ff;

    // ****************************************************************
    // two stages
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            meta_ff <= {WIDTH{1'b0}};
            q_sync <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= d_async;
            q_sync <= meta_ff;
        end
    end
endmodule // bst_sync2

//--- bst_tick.v
// millisecond enable divider with restart
`timescale 1ns/100ps
module bst_tick #(
    parameter CYCLES = 10000,  // clock cycles per tick
    parameter CW = 16          // counter width
) (
    input wire clk,     // system clock
    input wire rst,     // synchronous reset, high
    input wire restart, // realign the tick phase
    output reg tick     // one-cycle enable each period
);
    reg [CW-1:0] cnt_ff;                      // cycles into the period
    localparam [CW-1:0] LAST = CYCLES - 1;    // terminal count

    // ****************************************************************
    // divider
    // ****************************************************************
    always @(posedge clk) begin
        if (rst || restart) begin
            cnt_ff <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (cnt_ff == LAST) begin
            cnt_ff <= {CW{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // bst_tick
